// File: shared/bsr_pkg.sv
// constants shared by the bidirectional shift register block
package bsr_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int BSR_ADDR_W = 8;
  localparam logic [7:0] BSR_OFS_CTRL = 8'h00;
  localparam logic [7:0] BSR_OFS_VALUE = 8'h04;
  localparam logic [7:0] BSR_OFS_STATUS = 8'h08;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int BSR_CTRL_RUN_BIT = 0;
  localparam logic BSR_CTRL_RUN_RESET = 1'b1;
  localparam int BSR_STAT_STALL_BIT = 0;
  localparam int BSR_STAT_OUT_VALID_BIT = 1;
  localparam logic [1:0] BSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] BSR_RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // shift register defaults
  // ----------------------------------------
  typedef enum logic {BSR_EDGE_RISE, BSR_EDGE_FALL} bsr_edge_t;
  localparam int BSR_WIDTH_DEF = 8;
  localparam logic BSR_POL_DEF = 1'b1;
  localparam logic [31:0] BSR_CLEAR_DEF = 32'h00000000;
  localparam logic [31:0] BSR_PRESET_DEF = 32'hFFFFFFFF;
  localparam logic [31:0] BSR_INIT_DEF = 32'h00000000;

endpackage

// File: shared/bsr_stream_if.sv
// valid/ready word stream from the shift core to its output buffer and from the buffer to the receiver
`timescale 1ns/1ns
interface bsr_stream_if #(
  parameter int WIDTH = 8
) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: rtl/bsr_buf2.sv
// two-entry buffer, all outputs toward the receiver come from flip-flops
`timescale 1ns/1ns
module bsr_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  bsr_stream_if.snk up,
  bsr_stream_if.src dn
);
  logic out_valid;
  logic [WIDTH-1:0] out_data;
  logic spare_valid;
  logic [WIDTH-1:0] spare_data;
  logic push;
  logic pop;

  // the spare slot catches a word while the receiver stalls
  assign up.ready = !spare_valid;
  assign dn.valid = out_valid;
  assign dn.data = out_data;
  assign push = up.valid && !spare_valid;
  assign pop = out_valid && dn.ready;

  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      spare_valid <= 1'b0;
      spare_data <= '0;
    end else if (ce) begin
      if (!out_valid || pop) begin
        if (spare_valid) begin
          out_valid <= 1'b1;
          out_data <= spare_data;
          spare_valid <= 1'b0;
        end else begin
          out_valid <= push;
          if (push) begin
            out_data <= up.data;
          end
        end
      end else if (push) begin
        spare_valid <= 1'b1;
        spare_data <= up.data;
      end
    end
  end
endmodule

// File: rtl/bsr_shift_top.sv
// bidirectional shift register with parallel load, set/clear and AXI4-Lite status
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
module bsr_shift_top #(
  parameter int REGISTER_WIDTH = bsr_pkg::BSR_WIDTH_DEF,
  parameter bsr_pkg::bsr_edge_t CLOCK_EDGE_SELECT = bsr_pkg::BSR_EDGE_RISE,
  parameter logic DIR_POLARITY = bsr_pkg::BSR_POL_DEF,
  parameter logic LOAD_POLARITY = bsr_pkg::BSR_POL_DEF,
  parameter logic SET_CLEAR_POLARITY = bsr_pkg::BSR_POL_DEF,
  parameter logic [REGISTER_WIDTH-1:0] ASYNC_CLEAR_VALUE =
    REGISTER_WIDTH'(bsr_pkg::BSR_CLEAR_DEF),
  parameter logic [REGISTER_WIDTH-1:0] SYNC_CLEAR_VALUE =
    REGISTER_WIDTH'(bsr_pkg::BSR_CLEAR_DEF),
  parameter logic [REGISTER_WIDTH-1:0] ASYNC_PRESET_VALUE =
    REGISTER_WIDTH'(bsr_pkg::BSR_PRESET_DEF),
  parameter logic [REGISTER_WIDTH-1:0] SYNC_PRESET_VALUE =
    REGISTER_WIDTH'(bsr_pkg::BSR_PRESET_DEF),
  parameter logic [REGISTER_WIDTH-1:0] INITIAL_OUTPUT_VALUE =
    REGISTER_WIDTH'(bsr_pkg::BSR_INIT_DEF)
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic SHIFT_CLK,
  input wire logic DIR,
  input wire logic LOAD_SHIFT,
  input wire logic ASYNC_CLEAR,
  input wire logic ASYNC_PRESET,
  input wire logic SYNC_CLEAR,
  input wire logic SYNC_PRESET,
  input wire logic SERIAL_IN_LEFT,
  input wire logic SERIAL_IN_RIGHT,
  input wire logic [REGISTER_WIDTH-1:0] DATA_IN,
  output logic [REGISTER_WIDTH-1:0] Q,
  output logic WORD_VALID,
  input wire logic WORD_READY,
  output logic [REGISTER_WIDTH-1:0] WORD_DATA,
  input wire logic [bsr_pkg::BSR_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [bsr_pkg::BSR_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import bsr_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  // width sets length
  localparam int W = REGISTER_WIDTH;
  logic [W-1:0] q;
  logic [W-1:0] next_q;
  logic run;
  logic clk_prev;
  logic armed;
  logic edge_seen;
  logic step;
  logic aclr;
  logic apre;
  logic sclr;
  logic spre;
  logic left;
  logic load;
  logic edge_from;
  logic aw_got;
  logic w_got;
  logic [BSR_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  bsr_stream_if #(.WIDTH(W)) push_if ();
  bsr_stream_if #(.WIDTH(W)) pop_if ();

  // ----------------------------------------
  // pin decode
  // ----------------------------------------
  // set/clear level
  assign aclr = (ASYNC_CLEAR == SET_CLEAR_POLARITY);
  assign apre = (ASYNC_PRESET == SET_CLEAR_POLARITY);
  assign sclr = (SYNC_CLEAR == SET_CLEAR_POLARITY);
  assign spre = (SYNC_PRESET == SET_CLEAR_POLARITY);
  assign left = (DIR == DIR_POLARITY);
  assign load = (LOAD_SHIFT == LOAD_POLARITY);

  // ----------------------------------------
  // shift clock edge detect
  // ----------------------------------------
  // armed keeps a pin that is already high at reset release from faking an edge
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      clk_prev <= 1'b0;
      armed <= 1'b0;
    end else if (CE) begin
      clk_prev <= SHIFT_CLK;
      armed <= 1'b1;
    end
  end

  assign edge_from = (CLOCK_EDGE_SELECT == BSR_EDGE_FALL);
  assign edge_seen = armed && (clk_prev == edge_from) && (SHIFT_CLK != edge_from);
  // an edge that meets a full buffer or a stopped core is dropped, not queued
  assign step = CE && edge_seen && run && push_if.ready && !aclr && !apre;

  // ----------------------------------------
  // next value at a trigger edge
  // ----------------------------------------
  always_comb begin
    if (sclr) begin
      next_q = SYNC_CLEAR_VALUE;
    end else if (spre) begin
      next_q = SYNC_PRESET_VALUE;
    end else if (load) begin
      next_q = DATA_IN;
    end else if (left) begin
      next_q = {q[W-2:0], SERIAL_IN_RIGHT};
    end else begin
      next_q = {SERIAL_IN_LEFT, q[W-1:1]};
    end
  end

  // ----------------------------------------
  // register
  // ----------------------------------------
  // async pins act on the next system clock with CE high, without any shift clock edge
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      q <= INITIAL_OUTPUT_VALUE;
    end else if (CE) begin
      if (aclr) begin
        q <= ASYNC_CLEAR_VALUE;
      end else if (apre) begin
        q <= ASYNC_PRESET_VALUE;
      end else if (step) begin
        q <= next_q;
      end
    end
  end

  assign Q = q;

  // ----------------------------------------
  // output word buffer
  // ----------------------------------------
  assign push_if.valid = step;
  assign push_if.data = next_q;
  assign pop_if.ready = WORD_READY;
  assign WORD_VALID = pop_if.valid;
  assign WORD_DATA = pop_if.data;

  bsr_buf2 #(.WIDTH(W)) i_bsr_buf2 (
    .clk(MCLK),
    .srst(SRST),
    .ce(CE),
    .up(push_if),
    .dn(pop_if)
  );

  // ----------------------------------------
  // AXI4-Lite write
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= BSR_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      run <= BSR_CTRL_RUN_RESET;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end else if (!aw_got && !S_AXI_BVALID) begin
        S_AXI_AWREADY <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end else if (!w_got && !S_AXI_BVALID) begin
        S_AXI_WREADY <= 1'b1;
      end
      if (aw_got && w_got && !S_AXI_BVALID) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= BSR_RESP_OKAY;
        if (aw_addr == BSR_OFS_CTRL) begin
          if (w_strb[0]) begin
            run <= w_data[BSR_CTRL_RUN_BIT];
          end
        end else if (aw_addr != BSR_OFS_VALUE && aw_addr != BSR_OFS_STATUS) begin
          S_AXI_BRESP <= BSR_RESP_SLVERR;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= BSR_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= BSR_RESP_OKAY;
        S_AXI_RDATA <= '0;
        unique case (S_AXI_ARADDR)
          BSR_OFS_CTRL: begin
            S_AXI_RDATA[BSR_CTRL_RUN_BIT] <= run;
          end
          BSR_OFS_VALUE: begin
            // widths above 32 show only their low word
            S_AXI_RDATA <= 32'(q);
          end
          BSR_OFS_STATUS: begin
            S_AXI_RDATA[BSR_STAT_STALL_BIT] <= !push_if.ready;
            S_AXI_RDATA[BSR_STAT_OUT_VALID_BIT] <= pop_if.valid;
          end
          default: begin
            S_AXI_RRESP <= BSR_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end else if (!S_AXI_RVALID) begin
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);

  sequence s_trig_edge;
    CE && armed && SHIFT_CLK == edge_from ##1 CE && SHIFT_CLK != edge_from;
  endsequence

  sequence s_step_free;
    run && push_if.ready && !aclr && !apre;
  endsequence

  AST_INIT: assert property ($fell(SRST) |-> q == INITIAL_OUTPUT_VALUE)
    else $error("register not at initial value after reset");

  AST_ASYNC_CLEAR: assert property (CE && ASYNC_CLEAR == SET_CLEAR_POLARITY
      |=> q == ASYNC_CLEAR_VALUE)
    else $error("async clear not applied");

  AST_ASYNC_PRESET: assert property (CE && !aclr && apre
      |=> q == ASYNC_PRESET_VALUE)
    else $error("async preset not applied");

  AST_SYNC_CLEAR: assert property (s_trig_edge ##0 (s_step_free and sclr)
      |=> q == SYNC_CLEAR_VALUE)
    else $error("sync clear not applied at trigger edge");

  AST_SYNC_PRESET: assert property (step && !sclr && SYNC_PRESET == SET_CLEAR_POLARITY
      |=> q == SYNC_PRESET_VALUE)
    else $error("sync preset not applied at trigger edge");

  AST_LOAD: assert property (step && !sclr && !spre && LOAD_SHIFT == LOAD_POLARITY
      |=> q == $past(DATA_IN))
    else $error("parallel load wrong");

  AST_SHIFT_LEFT: assert property (step && !sclr && !spre && !load && DIR == DIR_POLARITY
      |=> q == {$past(q[W-2:0]), $past(SERIAL_IN_RIGHT)})
    else $error("left shift wrong");

  AST_SHIFT_RIGHT: assert property (step && !sclr && !spre && !load && !left
      |=> q == {$past(SERIAL_IN_LEFT), $past(q[W-1:1])})
    else $error("right shift wrong");

  AST_TRIG_EDGE: assert property (s_trig_edge ##0 s_step_free |-> step)
    else $error("selected edge did not step the register");

  AST_HOLD: assert property (CE && !step && !aclr && !apre |=> $stable(q))
    else $error("register changed without an event");

  AST_PRIORITY: assert property (CE && aclr && apre |=> q == ASYNC_CLEAR_VALUE)
    else $error("clear did not win over preset");

  AST_SYNC_PRIORITY: assert property (step && sclr && spre |=> q == SYNC_CLEAR_VALUE)
    else $error("sync clear did not win over sync preset");

  AST_STALL_DROP: assert property (CE && edge_seen && !push_if.ready && !aclr && !apre
      |=> q == $past(q))
    else $error("edge taken while the output buffer was full");

endmodule

// File: sim/bsr_rx_model.sv
// receiver model on the word stream: takes words, stalls at random or on command
`timescale 1ns/1ns
module bsr_rx_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic hold,
  output logic ready
);
  // ----------------------------------------
  // ready pattern
  // ----------------------------------------
  // random short stalls keep the output buffer busy without ever losing a word
  always_ff @(posedge clk) begin
    if (srst) begin
      ready <= 1'b0;
    end else begin
      ready <= !hold && ($urandom_range(3) != 0);
    end
  end
endmodule

// File: sim/test_bidir_shift_register.sv
// self-checking bench for the bidirectional shift register top
`timescale 1ns/1ns
module test_bidir_shift_register;
  import bsr_pkg::*;
  localparam logic [7:0] S_CLR = 8'h3C;
  localparam logic [7:0] S_PRE = 8'hA5;
  localparam logic [7:0] A_CLR = 8'h0F;
  localparam logic [7:0] A_PRE = 8'hF0;
  localparam logic [7:0] INIT = 8'h5A;
  logic mclk = 0, srst = 1, shift_clk = 0, dir = 0, load_shift = 0, ser_l = 0, ser_r = 0;
  logic async_clear = 0, async_preset = 0, sync_clear = 0, sync_preset = 0, hold = 0, ce = 1;
  logic [7:0] data_in = 0, q, word_data, mq, q_inv, word_data_inv, e_w;
  logic word_valid, word_ready, awready, wready, bvalid, arready, rvalid, word_valid_inv;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] exp_q[$];
  int n_mismatch = 0, cmp_count = 0, cyc = 0;

  bsr_shift_top #(.SYNC_CLEAR_VALUE(S_CLR), .SYNC_PRESET_VALUE(S_PRE),
    .ASYNC_CLEAR_VALUE(A_CLR), .ASYNC_PRESET_VALUE(A_PRE),
    .INITIAL_OUTPUT_VALUE(INIT)) i_bsr_shift_top (
    .MCLK(mclk), .SRST(srst), .CE(ce), .SHIFT_CLK(shift_clk), .DIR(dir),
    .LOAD_SHIFT(load_shift), .ASYNC_CLEAR(async_clear), .ASYNC_PRESET(async_preset),
    .SYNC_CLEAR(sync_clear), .SYNC_PRESET(sync_preset), .SERIAL_IN_LEFT(ser_l),
    .SERIAL_IN_RIGHT(ser_r), .DATA_IN(data_in), .Q(q), .WORD_VALID(word_valid),
    .WORD_READY(word_ready), .WORD_DATA(word_data), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  // mirror copy: every polarity and the trigger edge inverted, fed the inverted pins
  bsr_shift_top #(.CLOCK_EDGE_SELECT(BSR_EDGE_FALL), .DIR_POLARITY(1'b0),
    .LOAD_POLARITY(1'b0), .SET_CLEAR_POLARITY(1'b0), .SYNC_CLEAR_VALUE(S_CLR),
    .SYNC_PRESET_VALUE(S_PRE), .ASYNC_CLEAR_VALUE(A_CLR), .ASYNC_PRESET_VALUE(A_PRE),
    .INITIAL_OUTPUT_VALUE(INIT)) i_bsr_shift_top_inv (
    .MCLK(mclk), .SRST(srst), .CE(ce), .SHIFT_CLK(!shift_clk), .DIR(!dir),
    .LOAD_SHIFT(!load_shift), .ASYNC_CLEAR(!async_clear), .ASYNC_PRESET(!async_preset),
    .SYNC_CLEAR(!sync_clear), .SYNC_PRESET(!sync_preset), .SERIAL_IN_LEFT(ser_l),
    .SERIAL_IN_RIGHT(ser_r), .DATA_IN(data_in), .Q(q_inv), .WORD_VALID(word_valid_inv),
    .WORD_READY(word_ready), .WORD_DATA(word_data_inv), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
    .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(),
    .S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rready));

  bsr_rx_model i_bsr_rx_model (.clk(mclk), .srst(srst), .hold(hold), .ready(word_ready));

  initial begin
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------
  // comparison and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // the watchdog ends a hung wait, so bus waits below carry no count of their own
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // stream watcher: each taken word against the oldest note, mirror copy in step
  always @(posedge mclk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'(word_data), 32'hDEAD); // word without a step
      end else begin
        e_w = exp_q.pop_front();
        check(32'(word_data), 32'(e_w)); // word order
        check(32'({word_valid_inv, word_data_inv}), 32'({1'b1, e_w})); // mirror stream
      end
    end
  end

  // ----------------------------------------
  // bus and pin tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (awvalid && awready !== 1'b1 || wvalid && wready !== 1'b1);
    while (bvalid !== 1'b1) @(posedge mclk);
    check(32'(bresp), 32'(er));
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    check(rdata, ed);
    check(32'(rresp), 32'(er));
    rready <= 0;
  endtask

  task automatic step(input logic ld, input logic lft, input logic sc, input logic sp,
                      input logic take);
    logic [7:0] d;
    logic sl;
    logic sr;
    logic [7:0] e;
    d = 8'($urandom);
    sl = 1'($urandom);
    sr = 1'($urandom);
    @(posedge mclk);
    data_in <= d;
    ser_l <= sl;
    ser_r <= sr;
    load_shift <= ld;
    dir <= lft;
    sync_clear <= sc;
    sync_preset <= sp;
    shift_clk <= 0;
    @(posedge mclk);
    shift_clk <= 1;
    if (sc) e = S_CLR;
    else if (sp) e = S_PRE;
    else if (ld) e = d;
    else if (lft) e = {mq[6:0], sr};
    else e = {sl, mq[7:1]};
    if (take) begin
      mq = e;
      exp_q.push_back(e);
    end
    repeat (3) @(posedge mclk);
    sync_clear <= 0;
    sync_preset <= 0;
    check(32'(q), 32'(mq)); // one step per edge
    check(32'(q_inv), 32'(mq)); // mirror copy
  endtask

  task automatic async_hit(input logic ac, input logic ap, input logic [7:0] e);
    @(posedge mclk);
    async_clear <= ac;
    async_preset <= ap;
    repeat (2) @(posedge mclk);
    check(32'(q), 32'(e)); // async values
    check(32'(q_inv), 32'(e)); // mirror async values
    async_clear <= 0;
    async_preset <= 0;
    mq = e;
  endtask

  task automatic done(input string name);
    $display("test %0s finished", name);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(30383));
    repeat (5) @(posedge mclk);
    srst <= 0;
    mq = INIT;
    repeat (3) @(posedge mclk);
    check(32'(q), 32'(INIT)); // initial output
    axi_rd(BSR_OFS_CTRL, 32'h1, BSR_RESP_OKAY);
    axi_rd(BSR_OFS_VALUE, 32'(INIT), BSR_RESP_OKAY); // value width
    axi_rd(8'h0C, 32'h0, BSR_RESP_SLVERR);
    axi_wr(8'h10, 32'h0, BSR_RESP_SLVERR);
    axi_wr(BSR_OFS_VALUE, 32'hFF, BSR_RESP_OKAY);
    axi_rd(BSR_OFS_VALUE, 32'(INIT), BSR_RESP_OKAY);
    // a write with no byte enabled must leave run set
    wstrb <= 4'h0;
    axi_wr(BSR_OFS_CTRL, 32'h0, BSR_RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(BSR_OFS_CTRL, 32'h1, BSR_RESP_OKAY);
    done("reset_and_map");
    for (int i = 0; i < 24; i++) begin
      step(i % 6 == 0, 1'($urandom), 0, 0, 1); // random steps
    end
    done("load_shift");
    @(posedge mclk);
    shift_clk <= 0;
    repeat (3) @(posedge mclk);
    check(32'(q), 32'(mq)); // falling edge ignored
    check(32'(q_inv), 32'(mq)); // mirror ignores its rising edge
    step(0, 1, 1, 0, 1);
    step(1, 0, 0, 1, 1);
    step(1, 1, 1, 1, 1); // clear wins over preset
    done("sync_set_clear");
    async_hit(1, 0, A_CLR); // async clear
    async_hit(0, 1, A_PRE); // async preset
    async_hit(1, 1, A_CLR); // clear wins
    done("async_set_clear");
    while (exp_q.size() != 0) @(posedge mclk);
    // clock enable low: the edge inside this step must leave both copies alone
    ce <= 0;
    step(1, 0, 0, 0, 0);
    ce <= 1;
    done("clock_enable");
    axi_wr(BSR_OFS_CTRL, 32'h0, BSR_RESP_OKAY);
    step(1, 0, 0, 0, 0);
    axi_wr(BSR_OFS_CTRL, 32'h1, BSR_RESP_OKAY);
    done("run_off");
    while (exp_q.size() != 0) @(posedge mclk);
    hold <= 1;
    step(1, 0, 0, 0, 1);
    step(0, 1, 0, 0, 1);
    step(1, 0, 0, 0, 0);
    axi_rd(BSR_OFS_STATUS, 32'h3, BSR_RESP_OKAY);
    hold <= 0;
    while (exp_q.size() != 0) @(posedge mclk);
    repeat (4) @(posedge mclk);
    axi_rd(BSR_OFS_STATUS, 32'h0, BSR_RESP_OKAY);
    axi_rd(BSR_OFS_VALUE, 32'(mq), BSR_RESP_OKAY); // value readback
    done("buffer_full");
    end_of_test();
  end
endmodule
